// file: rtl/imsr_defs.svh
`ifndef IMSR_DEFS_SVH
`define IMSR_DEFS_SVH

// register offsets
`define IMSR_REG_CTRL 2'h0
`define IMSR_REG_STAT 2'h1
`define IMSR_REG_DATA 2'h2
`define IMSR_REG_OWN  2'h3

// control register bit positions
`define IMSR_CTRL_INT   7
`define IMSR_CTRL_ACK   6
`define IMSR_CTRL_BEGIN 5
`define IMSR_CTRL_HALT  4
`define IMSR_CTRL_WCOL  3
`define IMSR_CTRL_EN    2
`define IMSR_CTRL_IE    0

// reset values
`define IMSR_OWN_RESET  8'hfe
`define IMSR_DATA_RESET 8'hff

// status codes, prescaler bits zero
`define IMSR_ST_START     8'h08
`define IMSR_ST_REP_START 8'h10
`define IMSR_ST_AW_ACK    8'h18
`define IMSR_ST_AW_NACK   8'h20
`define IMSR_ST_DT_ACK    8'h28
`define IMSR_ST_DT_NACK   8'h30
`define IMSR_ST_ARB_LOST  8'h38
`define IMSR_ST_AR_ACK    8'h40
`define IMSR_ST_AR_NACK   8'h48
`define IMSR_ST_DR_ACK    8'h50
`define IMSR_ST_DR_NACK   8'h58
`define IMSR_ST_SW_ACK    8'h60
`define IMSR_ST_SW_ARB    8'h68
`define IMSR_ST_GC_ACK    8'h70
`define IMSR_ST_GC_ARB    8'h78
`define IMSR_ST_SD_ACK    8'h80
`define IMSR_ST_SD_NACK   8'h88
`define IMSR_ST_GD_ACK    8'h90
`define IMSR_ST_GD_NACK   8'h98
`define IMSR_ST_NONE      8'hf8

// timing
`define IMSR_SYS_PERIOD_NS 100
`define IMSR_BUS_HALF_NS   2500
`define IMSR_HALF_CYCLES   ((`IMSR_BUS_HALF_NS) / (`IMSR_SYS_PERIOD_NS))

`endif

// file: rtl/imsr_pkg.sv
package imsr_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_XFER  = 5'h04,
    ST_HOLD  = 5'h08,
    ST_STOP  = 5'h10
  } imsr_state_e;

endpackage

// file: rtl/imsr_receiver.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`include "imsr_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module imsr_receiver
  import imsr_pkg::*;
#(
  parameter logic [15:0] HALF_CYCLES = 16'(`IMSR_HALF_CYCLES)
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output var  logic [7:0] regRdData,
  input  wire logic       sclIn,
  output var  logic       sclOut,
  output var  logic       sclOe,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOe,
  input  wire logic       sleepDeep,
  output var  logic       irq,
  output var  logic       wakeReq
);

  imsr_state_e state;
  logic        sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
  logic        intFlag, ackEnable, beginReq, haltReq, wrColl, ifaceEn, intEn;
  logic [1:0]  presc;
  logic [7:0]  statusCode, dataReg, ownAddr, shiftReg;
  logic [3:0]  bitCnt;
  logic [1:0]  phase;
  logic [15:0] tickCnt;
  logic        isMaster, isTx, addrByte, gcMode, arbLost, busBusy;
  logic        sdaLow, mSclLow, holdBus, ackGiven, sampledBit;

  function automatic logic [1:0] addrMatch(input logic [7:0] rx, input logic [7:0] own);
    addrMatch = {rx[7:1] == 7'h00 && own[0], rx[7:1] == own[7:1]};
  endfunction

  wire        sclRise   = sclSync & ~sclPrev;
  wire        sclFall   = ~sclSync & sclPrev;
  wire        startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
  wire        stopSeen  = sclSync & sclPrev & ~sdaPrev & sdaSync;
  wire [15:0] tickLimit = HALF_CYCLES << {presc, 1'b0};
  wire        tickStall = state == ST_XFER && isMaster && !mSclLow && !sclSync;
  wire        tick      = tickCnt >= tickLimit;
  wire        ctrlWr    = regWrEn && regAddr == `IMSR_REG_CTRL;
  wire        dataWr    = regWrEn && regAddr == `IMSR_REG_DATA;
  wire        inXfer    = state == ST_XFER;
  wire        bitEnd7   = inXfer && sclFall && bitCnt == 4'h7;
  wire        byteEnd   = inXfer && sclFall && bitCnt == 4'h8;
  wire        addrDec   = bitEnd7 && addrByte && !isTx;
  wire        rxDec     = bitEnd7 && !addrByte && !isTx;
  wire [1:0]  hit       = addrMatch(shiftReg, ownAddr);
  wire        addrAck   = (|hit) && ackEnable && !shiftReg[0];
  wire        nackLost  = inXfer && sclRise && isMaster && !isTx && bitCnt == 4'h8
                          && !sdaLow && !sdaSync;
  wire        bitLost   = inXfer && sclRise && isMaster && isTx && bitCnt < 4'h8
                          && !sdaLow && !sdaSync;
  wire        resume    = state == ST_HOLD && !intFlag;
  wire        codeMRx   = statusCode == `IMSR_ST_AR_ACK || statusCode == `IMSR_ST_DR_ACK;
  wire        codeATx   = statusCode == `IMSR_ST_START || statusCode == `IMSR_ST_REP_START;
  wire        codeDTx   = statusCode == `IMSR_ST_AW_ACK || statusCode == `IMSR_ST_AW_NACK
                          || statusCode == `IMSR_ST_DT_ACK || statusCode == `IMSR_ST_DT_NACK;
  wire        codeSRx   = statusCode[7:4] >= 4'h6 && statusCode[7:4] <= 4'h9
                          && !statusCode[3];
  wire        mTxAck    = !sampledBit;
  wire [7:0]  mstCode   = !isTx ? (ackGiven ? `IMSR_ST_DR_ACK : `IMSR_ST_DR_NACK)
                        : !addrByte ? (mTxAck ? `IMSR_ST_DT_ACK : `IMSR_ST_DT_NACK)
                        : shiftReg[0] ? (mTxAck ? `IMSR_ST_AR_ACK : `IMSR_ST_AR_NACK)
                        : (mTxAck ? `IMSR_ST_AW_ACK : `IMSR_ST_AW_NACK);
  wire [7:0]  slvCode   = addrByte ? (gcMode ? (arbLost ? `IMSR_ST_GC_ARB : `IMSR_ST_GC_ACK)
                                             : (arbLost ? `IMSR_ST_SW_ARB : `IMSR_ST_SW_ACK))
                        : gcMode ? (ackGiven ? `IMSR_ST_GD_ACK : `IMSR_ST_GD_NACK)
                        : (ackGiven ? `IMSR_ST_SD_ACK : `IMSR_ST_SD_NACK);
  wire [7:0]  byteCode  = isMaster ? mstCode : slvCode;
  wire [7:0]  ctrlView  = {intFlag, ackEnable, beginReq, haltReq, wrColl, ifaceEn, 1'b0, intEn};
  wire [7:0]  readMux   = regAddr == `IMSR_REG_CTRL ? ctrlView
                        : regAddr == `IMSR_REG_STAT ? {statusCode[7:3], 1'b0, presc}
                        : regAddr == `IMSR_REG_DATA ? dataReg : ownAddr;

  // two-stage synchronisers; stage one read only by stage two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {sclMeta, sclSync, sclPrev} <= 3'h7;
      {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
    end else begin
      {sclMeta, sclSync, sclPrev} <= {sclIn, sclMeta, sclSync};
      {sdaMeta, sdaSync, sdaPrev} <= {sdaIn, sdaMeta, sdaSync};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busBusy <= 1'b0;
      tickCnt <= 16'h0000;
    end else begin
      busBusy <= startSeen ? 1'b1 : stopSeen ? 1'b0 : busBusy;
      tickCnt <= tick ? 16'h0000 : tickStall ? tickCnt : tickCnt + 16'h0001;
    end
  end

  // read data, pin and request outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
      sclOut    <= 1'b0;
      sdaOut    <= 1'b0;
      sclOe     <= 1'b0;
      sdaOe     <= 1'b0;
      irq       <= 1'b0;
    end else begin
      regRdData <= regRdEn ? readMux : 8'h00;
      sclOut    <= 1'b0;
      sdaOut    <= 1'b0;
      sclOe     <= mSclLow | (intFlag & holdBus);
      sdaOe     <= sdaLow;
      irq       <= intFlag & intEn;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      {intFlag, ackEnable, beginReq, haltReq, wrColl, ifaceEn, intEn} <= 7'h00;
      presc      <= 2'h0;
      statusCode <= `IMSR_ST_NONE;
      dataReg    <= `IMSR_DATA_RESET;
      ownAddr    <= `IMSR_OWN_RESET;
      shiftReg   <= 8'h00;
      bitCnt     <= 4'h0;
      phase      <= 2'h0;
      {isMaster, isTx, addrByte, gcMode, arbLost} <= 5'h00;
      {sdaLow, mSclLow, holdBus, ackGiven, sampledBit, wakeReq} <= 6'h00;
    end else begin
      if (ctrlWr && regWrData[`IMSR_CTRL_INT])
        intFlag <= 1'b0;
      if (dataWr) begin
        if (intFlag) begin
          dataReg <= regWrData;
          wrColl  <= 1'b0;
        end else begin
          wrColl  <= 1'b1;
        end
      end
      if (regWrEn && regAddr == `IMSR_REG_STAT)
        presc <= regWrData[1:0];
      if (regWrEn && regAddr == `IMSR_REG_OWN)
        ownAddr <= regWrData;
      if (!ifaceEn) begin
        state <= ST_IDLE;
        {isMaster, sdaLow, mSclLow, holdBus} <= 4'h0;
      end else begin
        case (state)
          ST_IDLE: begin
            {sdaLow, mSclLow, isMaster} <= 3'h0;
            phase <= 2'h0;
            if (startSeen) begin
              state    <= ST_XFER;
              bitCnt   <= 4'hf; // start's own falling clock wraps it to zero
              {addrByte, isTx, arbLost} <= 3'h4;
            end else if (beginReq && !intFlag) begin
              state <= ST_START;
            end
          end
          ST_START: begin
            if (startSeen && !sdaLow && !isMaster) begin
              state    <= ST_XFER;
              bitCnt   <= 4'hf;
              {addrByte, isTx, arbLost} <= 3'h4;
            end else if (tick) begin
              case (phase)
                2'h0: begin
                  {sdaLow, mSclLow} <= 2'h0;
                  phase <= 2'h1;
                end
                2'h1: begin
                  if (sclSync && sdaSync && (isMaster || !busBusy)) begin
                    sdaLow <= 1'b1;
                    phase  <= 2'h2;
                  end
                end
                default: begin
                  mSclLow    <= 1'b1;
                  intFlag    <= 1'b1;
                  statusCode <= isMaster ? `IMSR_ST_REP_START : `IMSR_ST_START;
                  isMaster   <= 1'b1;
                  holdBus    <= 1'b1;
                  phase      <= 2'h0;
                  state      <= ST_HOLD;
                end
              endcase
            end
          end
          ST_XFER: begin
            if (tick && isMaster)
              mSclLow <= ~mSclLow;
            if (!isMaster && stopSeen) begin
              state  <= ST_IDLE;
              sdaLow <= 1'b0;
            end else if (!isMaster && startSeen) begin
              bitCnt   <= 4'hf;
              {addrByte, isTx, arbLost, sdaLow} <= 4'h8;
            end else if (nackLost) begin
              {isMaster, mSclLow, sdaLow} <= 3'h0;
              intFlag    <= 1'b1;
              statusCode <= `IMSR_ST_ARB_LOST;
              state      <= ST_IDLE;
            end else if (sclRise) begin
              sampledBit <= sdaSync;
              if (bitCnt < 4'h8)
                shiftReg <= {shiftReg[6:0], sdaSync};
              if (bitLost) begin
                {isMaster, mSclLow, sdaLow} <= 3'h0;
                isTx    <= 1'b0;
                arbLost <= 1'b1;
              end
            end else if (bitEnd7) begin
              bitCnt <= 4'h8;
              if (isTx) begin
                sdaLow <= 1'b0;
              end else if (addrByte) begin
                sdaLow   <= addrAck;
                ackGiven <= addrAck;
                gcMode   <= hit[1] && !hit[0];
                if (addrAck && sleepDeep)
                  wakeReq <= 1'b1;
                if (!addrAck) begin
                  state <= ST_IDLE;
                  if (arbLost) begin
                    intFlag    <= 1'b1;
                    statusCode <= `IMSR_ST_ARB_LOST;
                  end
                end
              end else begin
                sdaLow   <= ackEnable;
                ackGiven <= ackEnable;
                if (!sleepDeep)
                  dataReg <= shiftReg;
              end
            end else if (byteEnd) begin
              sdaLow     <= 1'b0;
              intFlag    <= 1'b1;
              statusCode <= byteCode;
              holdBus    <= 1'b1;
              state      <= ST_HOLD;
            end else if (sclFall) begin
              bitCnt <= bitCnt + 4'h1;
              sdaLow <= isTx & ~shiftReg[7];
            end
          end
          ST_HOLD: begin
            if (resume) begin
              holdBus  <= 1'b0;
              statusCode <= `IMSR_ST_NONE; // nothing pending once released
              wakeReq  <= 1'b0;
              bitCnt   <= 4'h0;
              shiftReg <= dataReg;
              phase    <= 2'h0;
              if (isMaster && haltReq) begin
                state <= ST_STOP;
              end else if (isMaster && codeMRx) begin
                state <= ST_XFER;
                {isTx, addrByte, sdaLow} <= 3'h0;
              end else if (isMaster && codeATx) begin
                state    <= ST_XFER;
                {isTx, addrByte} <= 2'h3;
                sdaLow   <= ~dataReg[7];
              end else if (isMaster && beginReq) begin
                state <= ST_START;
              end else if (isMaster && codeDTx) begin
                state    <= ST_XFER;
                {isTx, addrByte} <= 2'h2;
                sdaLow   <= ~dataReg[7];
              end else if (!isMaster && codeSRx) begin
                state <= ST_XFER;
                {isTx, addrByte, sdaLow} <= 3'h0;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_STOP: begin
            if (tick) begin
              phase <= phase + 2'h1;
              case (phase)
                2'h0: sdaLow <= 1'b1;
                2'h1: mSclLow <= 1'b0;
                2'h2: sdaLow <= !sclSync;
                default: begin
                  haltReq  <= 1'b0;
                  isMaster <= 1'b0;
                  state    <= ST_IDLE;
                end
              endcase
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
      if (ctrlWr) begin
        ackEnable <= regWrData[`IMSR_CTRL_ACK];
        beginReq  <= regWrData[`IMSR_CTRL_BEGIN];
        haltReq   <= regWrData[`IMSR_CTRL_HALT];
        ifaceEn   <= regWrData[`IMSR_CTRL_EN];
        intEn     <= regWrData[`IMSR_CTRL_IE];
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ackDrive;
    sdaLow ##1 sdaOe;
  endsequence
  sequence s_holdLow;
    sclOe [*2];
  endsequence

  property p_ownAck;
    addrDec && addrAck |=> s_ackDrive;
  endproperty
  a_ownAck: assert property (p_ownAck) else $error("own address not acked");
  property p_gcIgnore;
    addrDec && shiftReg[7:1] == 7'h00 && !ownAddr[0] && ownAddr[7:1] != 7'h00 |=> !sdaLow;
  endproperty
  a_gcIgnore: assert property (p_gcIgnore) else $error("general call acked");
  property p_noAckOff;
    addrDec && !ackEnable |=> !sdaLow ##1 !sdaOe;
  endproperty
  a_noAckOff: assert property (p_noAckOff) else $error("address acked while disabled");
  property p_rxAck;
    rxDec |=> sdaLow == $past(ackEnable) ##1 sdaOe == $past(ackEnable, 2);
  endproperty
  a_rxAck: assert property (p_rxAck) else $error("data ack wrong");
  property p_holdScl;
    $rose(intFlag) && holdBus |=> s_holdLow;
  endproperty
  a_holdScl: assert property (p_holdScl) else $error("clock not held");
  property p_irq;
    intFlag && intEn |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");
  property p_wake;
    addrDec && addrAck && sleepDeep |=> wakeReq throughout (##[1:40] byteEnd);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not held");
  property p_wakeHold;
    wakeReq && intFlag && $past(intFlag) |-> sclOe;
  endproperty
  a_wakeHold: assert property (p_wakeHold) else $error("clock released before clear");
  property p_startCode;
    state == ST_START && tick && phase == 2'h2 |=> intFlag &&
      statusCode == ($past(isMaster) ? `IMSR_ST_REP_START : `IMSR_ST_START);
  endproperty
  a_startCode: assert property (p_startCode) else $error("start code wrong");
  property p_haltClr;
    $fell(haltReq) && !$past(ctrlWr) |-> $past(state == ST_STOP) && state == ST_IDLE;
  endproperty
  a_haltClr: assert property (p_haltClr) else $error("halt cleared outside stop");
  property p_wcoll;
    dataWr && !intFlag |=> wrColl && $stable(dataReg);
  endproperty
  a_wcoll: assert property (p_wcoll) else $error("data written without flag");

endmodule

`default_nettype wire

// file: tb/imsr_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none

module imsr_bus_partner #(
  parameter int HALF_NS = 400
) (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic pScl,
  output var  logic pSda
);
  initial begin
    pScl = 1'b1;
    pSda = 1'b1;
  end

  // data moves mid-low so it never looks like a start or stop
  // clock rises just past the slave's latest stretch point
  task automatic m_bit(input logic v, output logic seen);
    #(HALF_NS / 2 + 10);
    pSda = v;
    #(HALF_NS / 2);
    pScl = 1'b1;
    wait (scl === 1'b1);
    #(HALF_NS);
    seen = sda;
    pScl = 1'b0;
  endtask

  task automatic m_start();
    pSda = 1'b1;
    pScl = 1'b1;
    #(HALF_NS);
    pSda = 1'b0;
    #(HALF_NS);
    pScl = 1'b0;
  endtask

  task automatic m_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      m_bit(b[i], s);
    end
    m_bit(1'b1, ack);
  endtask

  task automatic m_stop();
    logic s;
    m_bit(1'b0, s);
    pScl = 1'b1;
    #(HALF_NS);
    pSda = 1'b1;
    #(HALF_NS);
  endtask

  task automatic s_addr(input logic ack);
    repeat (8) @(posedge scl);
    @(negedge scl);
    #(HALF_NS / 2);
    pSda = ~ack;
    @(negedge scl);
    #(HALF_NS / 2);
    pSda = 1'b1;
  endtask

  task automatic s_byte(input logic [7:0] b, output logic seen);
    for (int i = 7; i >= 0; i--) begin
      #(HALF_NS / 2);
      pSda = b[i];
      @(negedge scl);
    end
    #(HALF_NS / 2);
    pSda = 1'b1;
    @(posedge scl);
    #(HALF_NS / 2);
    seen = sda;
    @(negedge scl);
  endtask
endmodule

`default_nettype wire

// file: tb/test_i2c_master_slave_receiver.sv
`include "imsr_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module test_i2c_master_slave_receiver;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWrData = 8'h00;
  logic       regWrEn = 1'b0;
  logic       regRdEn = 1'b0;
  logic       sleepDeep = 1'b0;
  logic [7:0] regRdData;
  logic       sclOut, sclOe, sdaOut, sdaOe, irq, wakeReq, pScl, pSda;
  logic [31:0] seed = 32'd75115;
  logic [6:0] own, ta;
  logic [7:0] v, b1, b2;
  logic       s1, s2;
  int         fail_count = 0;
  int         comparisons = 0;
  wire        scl = (sclOe ? sclOut : 1'b1) & pScl;
  wire        sda = (sdaOe ? sdaOut : 1'b1) & pSda;

  always #50 sys_clk = ~sys_clk;

  imsr_receiver #(.HALF_CYCLES(16'h0004)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .sclIn(scl),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sleepDeep(sleepDeep), .irq(irq), .wakeReq(wakeReq));

  imsr_bus_partner partner (.scl(scl), .sda(sda), .pScl(pScl), .pSda(pSda));

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    check("irq", 8'(irq), 8'h01);
  endtask

  task automatic expect_status(input logic [7:0] exp);
    logic [7:0] st;
    rd(`IMSR_REG_STAT, st);
    check("status", st & 8'hf8, exp);
  endtask

  task automatic slave_case(input logic [7:0] ab, input logic [7:0] cfg, input logic slp,
                            input logic ok, input logic [7:0] aSt, input logic [7:0] dCtl,
                            input logic [7:0] dSt);
    logic       seen;
    logic [7:0] b, d;
    b = 8'(xorshift());
    wr(`IMSR_REG_CTRL, cfg);
    sleepDeep <= slp;
    partner.m_start();
    partner.m_byte(ab, seen);
    check("addr ack", 8'(seen), {7'h00, ~ok});
    if (ok) begin
      repeat (4) @(posedge sys_clk);
      check("wake", 8'(wakeReq), 8'(slp));
      sleepDeep <= 1'b0;
      wait_irq();
      check("scl held", 8'(scl), 8'h00);
      expect_status(aSt);
      fork
        partner.m_byte(b, seen);
        wr(`IMSR_REG_CTRL, dCtl);
      join
      check("data ack", 8'(seen), {7'h00, ~dCtl[6]});
      wait_irq();
      expect_status(dSt);
      rd(`IMSR_REG_DATA, d);
      check("data", d, b);
      wr(`IMSR_REG_CTRL, 8'hc5);
    end else begin
      repeat (20) @(posedge sys_clk);
      check("no irq", 8'(irq), 8'h00);
    end
    sleepDeep <= 1'b0;
    partner.m_stop();
    $display("slave case %h done", ab);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(2_000_000);
    fail_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    logic [7:0] rv [4];
    logic [7:0] resp [3];
    logic [7:0] rs [2];
    rv = '{8'h00, 8'hf8, 8'hff, `IMSR_OWN_RESET};
    resp = '{8'ha5, 8'hb5, 8'h95};
    rs = '{`IMSR_ST_REP_START, `IMSR_ST_START};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), v);
      check("reset value", v, rv[i]);
    end
    wr(`IMSR_REG_DATA, 8'h3c);
    rd(`IMSR_REG_CTRL, v);
    check("write collision", v & 8'h08, 8'h08);
    rd(`IMSR_REG_DATA, v);
    check("data kept", v, `IMSR_DATA_RESET);
    wr(`IMSR_REG_STAT, 8'h03);
    rd(`IMSR_REG_STAT, v);
    check("prescaler", v, 8'hfb);
    wr(`IMSR_REG_STAT, 8'h00);
    own = 7'(xorshift()) | 7'h01;
    wr(`IMSR_REG_OWN, {own, 1'b1});
    rd(`IMSR_REG_OWN, v);
    check("own addr", v, {own, 1'b1});
    $display("register test done");
    slave_case({own, 1'b0}, 8'h45, 1'b0, 1'b1, `IMSR_ST_SW_ACK, 8'hc5, `IMSR_ST_SD_ACK);
    slave_case({own, 1'b1}, 8'h45, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    slave_case(8'h00, 8'h45, 1'b0, 1'b1, `IMSR_ST_GC_ACK, 8'hc5, `IMSR_ST_GD_ACK);
    slave_case({own ^ 7'h40, 1'b0}, 8'h45, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    slave_case({own, 1'b0}, 8'h05, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    slave_case({own, 1'b0}, 8'h45, 1'b1, 1'b1, `IMSR_ST_SW_ACK, 8'h85, `IMSR_ST_SD_NACK);
    wr(`IMSR_REG_OWN, {own, 1'b0});
    slave_case(8'h00, 8'h45, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    ta = 7'(xorshift());
    b1 = 8'(xorshift());
    b2 = 8'(xorshift());
    wr(`IMSR_REG_CTRL, 8'ha5);
    wait_irq();
    expect_status(`IMSR_ST_START);
    wr(`IMSR_REG_DATA, {ta, 1'b1});
    fork
      begin
        partner.s_addr(1'b1);
        partner.s_byte(b1, s1);
        partner.s_byte(b2, s2);
      end
      begin
        wr(`IMSR_REG_CTRL, 8'h85);
        wait_irq();
        expect_status(`IMSR_ST_AR_ACK);
        wr(`IMSR_REG_CTRL, 8'hc5);
        wait_irq();
        expect_status(`IMSR_ST_DR_ACK);
        rd(`IMSR_REG_DATA, v);
        check("rx byte", v, b1);
        wr(`IMSR_REG_CTRL, 8'h85);
        wait_irq();
        expect_status(`IMSR_ST_DR_NACK);
        rd(`IMSR_REG_DATA, v);
        check("rx byte", v, b2);
      end
    join
    check("ack sent", 8'(s1), 8'h00);
    check("nack sent", 8'(s2), 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(`IMSR_REG_CTRL, resp[i]);
      if (i < 2) begin
        wait_irq();
        expect_status(rs[i]);
        wr(`IMSR_REG_DATA, {ta, 1'b1});
        fork
          partner.s_addr(1'b0);
          wr(`IMSR_REG_CTRL, 8'h85);
        join
        wait_irq();
        expect_status(`IMSR_ST_AR_NACK);
      end
    end
    repeat (40) @(posedge sys_clk);
    rd(`IMSR_REG_CTRL, v);
    check("halt cleared", v & 8'h10, 8'h00);
    expect_status(`IMSR_ST_NONE);
    check("bus free", {6'h00, scl, sda}, 8'h03);
    $display("master receive test done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
